// File: verilog/sxc_pkg.sv
package sxc_pkg;
  // ---------------------------------------------------------------
  // recovery timing
  // ---------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam logic [11:0] REC_LONG_CYC = 12'hFFF; // 4096 cycles, terminal at count 4095
  localparam logic [11:0] REC_SHORT_CYC = 12'h01F; // 32 cycles, terminal at count 31
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam int NUM_IRQ = 8;

  // ---------------------------------------------------------------
  // exception and power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SXC_INIT = 3'b000,
    SXC_RUN = 3'b001,
    SXC_WAIT = 3'b010,
    SXC_STOP = 3'b011,
    SXC_RECOVER = 3'b100,
    SXC_STACK = 3'b101
  } sxc_state_t;

  // cpu handshake bundle
  typedef struct packed {
    logic instrDone;
    logic waitInstr;
    logic stopInstr;
    logic swiInstr;
    logic rtiInstr;
    logic stackDone;
  } sxc_cpu_t;
endpackage

// File: verilog/sxc_exception_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_exception_ctrl #(
  parameter int NUM_IRQ = sxc_pkg::NUM_IRQ
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic powerOnPulse,
  input wire logic extPinReset,
  input wire logic intReset,
  // oscillator clock as a sampled level
  input wire logic oscillatorClock,
  // configuration
  input wire logic shortRecoverySelect,
  input wire logic watchdogDisable,
  input wire logic breakFlagClearEnable,
  // cpu side
  input wire sxc_pkg::sxc_cpu_t cpuIn,
  input wire logic maskBit,
  // interrupt sources, bit 0 is highest priority
  input wire logic [NUM_IRQ-1:0] irqReq,
  input wire logic [NUM_IRQ-1:0] irqEn,
  // break module
  input wire logic breakReq,
  input wire logic breakExitedWaitWr0,
  // peripheral flag clear requests
  input wire logic flagClearReq,
  // clock generator controls
  output logic clockGenEnable,
  output logic cpuClockEnable,
  output logic periphClockEnable,
  output logic oscClockEnable,
  // cpu controls
  output logic intTake,
  output logic [3:0] vectorSel,
  output logic stackCurrentPc,
  output logic setMask,
  output logic clearMask,
  output logic stackHighIndex,
  output logic inBreak,
  output logic breakModuleActive,
  // flag protection
  output logic flagClearAllow,
  // status
  output logic breakExitedWait,
  output logic watchdogClock,
  output logic watchdogRun,
  output logic [11:0] recoveryCount
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  sxc_pkg::sxc_state_t state_reg, state_next;
  logic [11:0] cnt_reg;
  logic oscPrev_reg;
  logic shortSel_reg;
  logic recFromIrq_reg;
  logic irqLatched_reg;
  logic [3:0] vec_reg;
  logic swiVec_reg;
  logic maskPrev_reg;
  // decoded helpers
  logic oscFall;
  logic maskFall;
  logic recDone;
  logic anyIrq;
  logic [3:0] winner;
  logic stopExit;

  // picks lowest-index pending enabled request
  function automatic logic [3:0] prio(input logic [NUM_IRQ-1:0] r);
    prio = 4'hF;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        prio = 4'(i);
      end
    end
  endfunction

  // request decode and recovery terminal count
  assign oscFall = oscPrev_reg & ~oscillatorClock;
  assign maskFall = maskPrev_reg & ~maskBit;
  assign anyIrq = |(irqReq & irqEn);
  assign winner = prio(irqReq & irqEn);
  assign stopExit = anyIrq | breakReq;
  assign recDone = oscFall && (cnt_reg == (shortSel_reg ? sxc_pkg::REC_SHORT_CYC
                                                        : sxc_pkg::REC_LONG_CYC));

  // ---------------------------------------------------------------
  // oscillator and mask edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscPrev_reg <= 1'b0;
      maskPrev_reg <= 1'b0;
    end else begin
      oscPrev_reg <= oscillatorClock;
      maskPrev_reg <= maskBit;
    end
  end

  // ---------------------------------------------------------------
  // recovery counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= sxc_pkg::CNT_RST;
    end else if (intReset || powerOnPulse) begin
      cnt_reg <= sxc_pkg::CNT_RST; // internal reset clears, external pin does not
    end else if (state_reg == sxc_pkg::SXC_STOP) begin
      cnt_reg <= sxc_pkg::CNT_RST;
    end else if (state_reg == sxc_pkg::SXC_RUN && cpuIn.stopInstr) begin
      cnt_reg <= sxc_pkg::CNT_RST;
    end else if (oscFall) begin
      cnt_reg <= cnt_reg + 12'h001; // free running
    end
  end

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sxc_pkg::SXC_INIT: begin
        if (!powerOnPulse) begin
          state_next = sxc_pkg::SXC_RUN;
        end
      end
      sxc_pkg::SXC_RUN: begin
        if (cpuIn.instrDone && cpuIn.waitInstr) begin
          state_next = sxc_pkg::SXC_WAIT;
        end else if (cpuIn.instrDone && cpuIn.stopInstr) begin
          state_next = sxc_pkg::SXC_STOP;
        end
      end
      sxc_pkg::SXC_WAIT: begin
        if (anyIrq || breakReq) begin
          state_next = sxc_pkg::SXC_RUN;
        end
      end
      sxc_pkg::SXC_STOP: begin
        if (stopExit) begin
          state_next = sxc_pkg::SXC_RECOVER;
        end
      end
      sxc_pkg::SXC_RECOVER: begin
        if (recDone) begin
          state_next = sxc_pkg::SXC_RUN;
        end
      end
      default: begin
        state_next = sxc_pkg::SXC_INIT;
      end
    endcase
  end

  // state register; every reset overrides the next-state logic
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= sxc_pkg::SXC_INIT;
    end else if (powerOnPulse) begin
      state_reg <= sxc_pkg::SXC_INIT;
    end else if (intReset || extPinReset) begin
      state_reg <= sxc_pkg::SXC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // recovery select sample
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shortSel_reg <= 1'b0;
      recFromIrq_reg <= 1'b0;
    end else if (state_reg == sxc_pkg::SXC_STOP && stopExit) begin
      shortSel_reg <= shortRecoverySelect;
      recFromIrq_reg <= 1'b1;
    end else if (state_reg == sxc_pkg::SXC_RUN) begin
      recFromIrq_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt latch and arbitration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqLatched_reg <= 1'b0;
      vec_reg <= 4'h0;
      swiVec_reg <= 1'b0;
      intTake <= 1'b0;
      stackCurrentPc <= 1'b0;
    end else if (intReset || extPinReset || powerOnPulse) begin
      irqLatched_reg <= 1'b0;
      intTake <= 1'b0;
      stackCurrentPc <= 1'b0;
      swiVec_reg <= 1'b0;
    end else begin
      intTake <= 1'b0;
      // release once stacking ends or the mask bit is cleared
      if (irqLatched_reg && (cpuIn.stackDone || maskFall)) begin
        irqLatched_reg <= 1'b0;
      end
      if (state_reg == sxc_pkg::SXC_RUN && !irqLatched_reg && cpuIn.instrDone) begin
        if (breakReq) begin
          irqLatched_reg <= 1'b1;
          swiVec_reg <= 1'b1;
          stackCurrentPc <= 1'b1;
          intTake <= 1'b1;
        end else if (cpuIn.swiInstr) begin
          irqLatched_reg <= 1'b1;
          swiVec_reg <= 1'b1;
          stackCurrentPc <= 1'b1;
          intTake <= 1'b1;
        end else if (anyIrq && !maskBit) begin
          irqLatched_reg <= 1'b1;
          vec_reg <= winner;
          swiVec_reg <= 1'b0;
          stackCurrentPc <= 1'b0;
          intTake <= 1'b1;
        end
      end else if ((state_reg == sxc_pkg::SXC_WAIT && anyIrq) ||
                   (state_reg == sxc_pkg::SXC_RECOVER && recDone && recFromIrq_reg && anyIrq)) begin
        // wake from wait, or take after the full stop recovery
        irqLatched_reg <= 1'b1;
        vec_reg <= winner;
        swiVec_reg <= 1'b0;
        stackCurrentPc <= 1'b0;
        intTake <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // cpu and clock outputs
  // ---------------------------------------------------------------
  // enables follow the next state so they switch together with it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vectorSel <= 4'h0;
      setMask <= 1'b0;
      clearMask <= 1'b0;
      stackHighIndex <= 1'b0;
      clockGenEnable <= 1'b0;
      cpuClockEnable <= 1'b0;
      periphClockEnable <= 1'b0;
      oscClockEnable <= 1'b0;
      breakModuleActive <= 1'b0;
    end else begin
      vectorSel <= swiVec_reg ? 4'hF : vec_reg;
      setMask <= intTake;
      clearMask <= cpuIn.instrDone && (cpuIn.waitInstr || cpuIn.stopInstr);
      stackHighIndex <= 1'b0;
      clockGenEnable <= (state_next != sxc_pkg::SXC_INIT) && !powerOnPulse;
      cpuClockEnable <= state_next == sxc_pkg::SXC_RUN;
      periphClockEnable <= state_next == sxc_pkg::SXC_RUN ||
                           state_next == sxc_pkg::SXC_WAIT;
      oscClockEnable <= state_next != sxc_pkg::SXC_STOP;
      breakModuleActive <= state_next != sxc_pkg::SXC_STOP;
    end
  end

  // ---------------------------------------------------------------
  // break state and flag protection
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      inBreak <= 1'b0;
      flagClearAllow <= 1'b0;
    end else begin
      if (breakReq && state_reg != sxc_pkg::SXC_STOP) begin
        inBreak <= 1'b1;
      end else if (cpuIn.rtiInstr) begin
        inBreak <= 1'b0;
      end
      flagClearAllow <= flagClearReq && (!inBreak || breakFlagClearEnable);
    end
  end

  // ---------------------------------------------------------------
  // exited-wait flag, set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      breakExitedWait <= 1'b0;
    end else if (intReset || powerOnPulse) begin
      breakExitedWait <= 1'b0;
    end else if (state_reg == sxc_pkg::SXC_WAIT && breakReq) begin
      breakExitedWait <= 1'b1;
    end else if (breakExitedWaitWr0) begin
      breakExitedWait <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // watchdog clock and counter view
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdogClock <= 1'b0;
      watchdogRun <= 1'b0;
      recoveryCount <= sxc_pkg::CNT_RST;
    end else begin
      watchdogClock <= oscFall && (cnt_reg == sxc_pkg::REC_LONG_CYC);
      watchdogRun <= !watchdogDisable && (state_reg == sxc_pkg::SXC_RUN ||
                                          state_reg == sxc_pkg::SXC_WAIT);
      recoveryCount <= cnt_reg;
    end
  end
endmodule
`default_nettype wire

// File: tb/sxc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_cpu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // cpu side
  input wire logic intTake,
  output logic stackDone,
  output logic oscillatorClock
);
  logic oscClk_reg;
  logic [2:0] stack_reg;
  // oscillator at half the core rate
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) oscClk_reg <= 1'b0;
    else oscClk_reg <= ~oscClk_reg;
  end
  // stacking ends a few cycles after the take
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) stack_reg <= 3'h0;
    else if (intTake) stack_reg <= 3'h4;
    else if (stack_reg != 3'h0) stack_reg <= stack_reg - 3'h1;
  end
  assign oscillatorClock = oscClk_reg;
  assign stackDone = (stack_reg == 3'h1);
endmodule
`default_nettype wire

// File: tb/sxc_exception_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_exception_ctrl_checker (
  // clock, reset, inputs
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic powerOnPulse,
  input wire logic watchdogDisable,
  input wire logic breakFlagClearEnable,
  input wire logic breakReq,
  input wire sxc_pkg::sxc_cpu_t cpuIn,
  input wire logic maskBit,
  // watched outputs
  input wire logic clockGenEnable,
  input wire logic cpuClockEnable,
  input wire logic periphClockEnable,
  input wire logic intTake,
  input wire logic [3:0] vectorSel,
  input wire logic setMask,
  input wire logic clearMask,
  input wire logic stackHighIndex,
  input wire logic inBreak,
  input wire logic flagClearAllow,
  input wire logic watchdogRun,
  input wire logic [11:0] recoveryCount
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // relations between requests and answers
  a_power_hold: assert property (powerOnPulse |=> !clockGenEnable)
    else $error("clock enabled during power-on");
  a_mask_refuse: assert property (cpuIn.instrDone && maskBit && !cpuIn.swiInstr &&
    !breakReq && cpuClockEnable |=> !intTake)
    else $error("masked request taken");
  a_take_mask: assert property (intTake |=> setMask)
    else $error("mask not set on entry");
  a_hi_index: assert property (!stackHighIndex)
    else $error("high index stacked");
  a_swi_vector: assert property (cpuIn.instrDone && cpuIn.swiInstr && cpuClockEnable
    |-> ##2 vectorSel == 4'hF)
    else $error("software vector wrong");
  a_flag_guard: assert property (flagClearAllow |->
    $past(!inBreak || breakFlagClearEnable))
    else $error("flag cleared in break");
  a_low_clrmask: assert property (cpuIn.instrDone && (cpuIn.waitInstr || cpuIn.stopInstr)
    && cpuClockEnable |-> ##[1:2] clearMask)
    else $error("mask not cleared");
  a_wait_gate: assert property (cpuIn.instrDone && cpuIn.waitInstr && cpuClockEnable
    |=> !cpuClockEnable && periphClockEnable)
    else $error("wait clocks wrong");
  a_wdog_wait: assert property ((!cpuClockEnable && periphClockEnable
    && !watchdogDisable)[*2] |-> watchdogRun)
    else $error("watchdog idle in wait");
  a_stop_gate: assert property (cpuIn.instrDone && cpuIn.stopInstr && cpuClockEnable
    |=> (!cpuClockEnable && !periphClockEnable) ##1 recoveryCount == 12'h000)
    else $error("stop clocks or counter wrong");
  // main scenarios reached
  c_take: cover property (intTake);
  c_break_clear: cover property (inBreak && flagClearAllow);
  c_stop: cover property (!cpuClockEnable && !periphClockEnable);
endmodule
`default_nettype wire

// File: tb/sxc_exception_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_exception_ctrl_tb;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic powerOnPulse = 1'b1;
  logic extPinReset = 1'b0;
  logic intReset = 1'b0;
  logic shortRecoverySelect = 1'b0;
  logic watchdogDisable = 1'b0;
  logic breakFlagClearEnable = 1'b0;
  logic maskBit = 1'b0;
  logic breakReq = 1'b0;
  logic breakExitedWaitWr0 = 1'b0;
  logic flagClearReq = 1'b0;
  logic [4:0] op = 5'h00;
  logic [7:0] irqReq = 8'h00;
  logic [7:0] irqEn = 8'hFF;
  logic oscillatorClock, stackDone, clockGenEnable, cpuClockEnable, periphClockEnable;
  logic oscClockEnable, intTake, stackCurrentPc, setMask, clearMask, stackHighIndex, inBreak;
  logic breakModuleActive, flagClearAllow, breakExitedWait, watchdogClock, watchdogRun;
  logic [3:0] vectorSel;
  logic [11:0] recoveryCount;
  sxc_pkg::sxc_cpu_t cpuIn;
  int n_fail = 0;
  int compares = 0;
  int nTake = 0;
  int nAllow = 0;
  int nClr = 0;
  int nWd = 0;
  int cyc = 0;
  logic tkPrev = 1'b0;
  logic lastPc = 1'b0;
  logic lastSet = 1'b0;
  logic [3:0] lastVec = 4'h0;
  // op is {instrDone, wait, stop, swi, return}
  assign cpuIn = {op, stackDone};
  always #2.5 core_clk = ~core_clk;
  sxc_cpu_model partner (.core_clk, .rst_b, .intTake, .stackDone, .oscillatorClock);
  sxc_exception_ctrl dut (.core_clk, .rst_b, .powerOnPulse, .extPinReset, .intReset,
    .oscillatorClock, .shortRecoverySelect, .watchdogDisable, .breakFlagClearEnable, .cpuIn,
    .maskBit, .irqReq, .irqEn, .breakReq, .breakExitedWaitWr0, .flagClearReq, .clockGenEnable,
    .cpuClockEnable, .periphClockEnable, .oscClockEnable, .intTake, .vectorSel, .stackCurrentPc,
    .setMask, .clearMask, .stackHighIndex, .inBreak, .breakModuleActive, .flagClearAllow,
    .breakExitedWait, .watchdogClock, .watchdogRun, .recoveryCount);
  // pulse outputs sampled away from the launching edge
  always @(negedge core_clk) begin
    tkPrev <= intTake;
    if (intTake === 1'b1) nTake <= nTake + 1;
    if (flagClearAllow === 1'b1) nAllow <= nAllow + 1;
    if (clearMask === 1'b1) nClr <= nClr + 1;
    if (watchdogClock === 1'b1) nWd <= nWd + 1;
    if (tkPrev === 1'b1) begin
      lastVec <= vectorSel;
      lastPc <= stackCurrentPc;
      lastSet <= setMask;
    end
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t check %0d", $time, compares);
    end
  endtask
  task automatic issue(input logic [4:0] o);
    @(posedge core_clk);
    op <= o;
    @(posedge core_clk);
    op <= 5'h00;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic await_take(input int lim, output int n);
    int t0;
    t0 = nTake;
    n = 0;
    while (nTake == t0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic pulse_clear;
    @(posedge core_clk);
    flagClearReq <= 1'b1;
    @(posedge core_clk);
    flagClearReq <= 1'b0;
    settle(3);
  endtask
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    int n;
    int base;
    int lim;
    logic [3:0] v1;
    logic [11:0] c1;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    settle(4);
    chk(clockGenEnable === 1'b0);
    powerOnPulse <= 1'b0;
    settle(4);
    chk(clockGenEnable === 1'b1 && cpuClockEnable === 1'b1);
    maskBit <= 1'b1;
    irqReq <= 8'h04;
    base = nTake;
    issue(5'h10);
    irqEn <= 8'hFB;
    maskBit <= 1'b0;
    issue(5'h10);
    settle(4);
    chk(nTake == base);
    irqEn <= 8'hFF;
    irqReq <= 8'h06;
    issue(5'h10);
    await_take(8, n);
    settle(3);
    chk(lastSet === 1'b1 && lastVec !== 4'hF && lastPc === 1'b0);
    v1 = lastVec;
    irqReq <= 8'h04;
    settle(6);
    issue(5'h10);
    await_take(8, n);
    settle(3);
    chk(n < 8 && lastVec !== v1);
    irqReq <= 8'h00;
    maskBit <= 1'b1;
    settle(6);
    issue(5'h12);
    await_take(8, n);
    settle(3);
    chk(n < 8 && lastVec === 4'hF && lastPc === 1'b1);
    settle(6);
    breakReq <= 1'b1;
    issue(5'h10);
    await_take(8, n);
    settle(3);
    chk(n < 8 && lastVec === 4'hF && inBreak === 1'b1);
    base = nAllow;
    pulse_clear();
    chk(nAllow == base);
    breakFlagClearEnable <= 1'b1;
    pulse_clear();
    chk(nAllow == base + 1);
    breakReq <= 1'b0;
    maskBit <= 1'b0;
    settle(6);
    base = nClr;
    issue(5'h18);
    settle(3);
    chk(cpuClockEnable === 1'b0 && periphClockEnable === 1'b1 && nClr > base);
    chk(watchdogRun === 1'b1);
    irqReq <= 8'h01;
    await_take(8, n);
    chk(n < 8);
    irqReq <= 8'h00;
    settle(6);
    issue(5'h18);
    breakReq <= 1'b1;
    settle(4);
    chk(breakExitedWait === 1'b1);
    breakReq <= 1'b0;
    breakExitedWaitWr0 <= 1'b1;
    @(posedge core_clk);
    breakExitedWaitWr0 <= 1'b0;
    settle(6);
    chk(breakExitedWait === 1'b0);
    for (int i = 0; i < 2; i++) begin
      shortRecoverySelect <= (i == 0);
      issue(5'h14);
      settle(20);
      chk(!cpuClockEnable && !periphClockEnable && recoveryCount === 12'h000);
      chk(oscClockEnable === 1'b0 && breakModuleActive === 1'b0);
      irqReq <= 8'h01;
      repeat (3) @(posedge core_clk);
      shortRecoverySelect <= (i != 0);
      lim = (i == 0) ? 32 : 4096;
      await_take(2 * lim + 20, n);
      chk(n >= 2 * lim - 8 && n <= 2 * lim + 8);
      irqReq <= 8'h00;
      settle(6);
    end
    chk(nWd > 0);
    c1 = recoveryCount;
    settle(40);
    chk(recoveryCount - c1 >= 12'd18 && recoveryCount - c1 <= 12'd22);
    c1 = recoveryCount;
    extPinReset <= 1'b1;
    settle(4);
    extPinReset <= 1'b0;
    settle(4);
    chk(recoveryCount - c1 <= 12'd10);
    base = nTake;
    irqReq <= 8'h01;
    intReset <= 1'b1;
    issue(5'h10);
    intReset <= 1'b0;
    settle(4);
    chk(nTake == base && recoveryCount <= 12'd4);
    irqReq <= 8'h00;
    wrap_up();
  end
endmodule
bind sxc_exception_ctrl sxc_exception_ctrl_checker chk_i (.core_clk, .rst_b, .powerOnPulse,
  .watchdogDisable, .breakFlagClearEnable, .breakReq, .cpuIn, .maskBit, .clockGenEnable,
  .cpuClockEnable, .periphClockEnable, .intTake, .vectorSel, .setMask, .clearMask,
  .stackHighIndex, .inBreak, .flagClearAllow, .watchdogRun, .recoveryCount);
`default_nettype wire
